//--- rtl/cmc_top.sv
// CAN operating mode control, bus idle detect and receive filtering
//
// Function
// - Requested mode field at control bits 10:8
// - Current mode field at control bits 7:5
// - Mode changes wait for eleven recessive bits
// - Init mode: no traffic, clear counters, flags kept
// - Configuration registers writable only in init mode
// - No init entry while a frame transmits
// - Disable: no traffic, wake flag, counters kept
// - Code 001 enters disable after idle bus
// - Disable releases both pins to port control
// - Timing bit 14 enables receive line filter in disable mode only
// - Transmit waits for eleven recessive bits first
// - Disable during wait aborts pending transmit
// - Code 000 normal mode owns bus pins
// - Listen only: passive, no acks, counters frozen
// - Code 111 accepts everything, even errored frames
// - Loopback ties internal transmit to receive
// - Assembled messages stored only when filters pass, except in code 111
// - Receive flag set only on store
// - Store raises interrupt when enabled
// - Filters 0,1 to buffer 0; 2-5 to buffer 1
// - Completed message compared with filter values
// - Frame format must match filter extended select
// - Zero mask bits always match
`timescale 1ns/1ps
`default_nettype none
`include "cmc_cfg.svh"
module cmc_top (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              bus_receive_pin,
   output logic                   bus_transmit_pin,
   output logic                   bus_transmit_oe,
   output logic                   bus_receive_owned,
   input  wire logic              core_tx_bit,
   output logic                   bus_receive_line,
   output logic                   tx_start,
   input  wire logic              tx_busy,
   input  wire logic              tx_done,
   output logic                   ack_enable,
   output logic                   err_cnt_clear,
   output logic                   err_cnt_freeze,
   output logic                   accept_all,
   input  wire logic              rx_msg_valid,
   input  wire logic              rx_msg_error,
   input  wire logic              rx_msg_ide,
   input  wire cmc_pkg::cmc_id_t  rx_msg_id,
   input  wire logic [63:0]       rx_msg_data,
   output cmc_pkg::cmc_mode_t     current_op_mode,
   output logic                   rx_irq
);
   import cmc_pkg::*;

   // Register state
   cmc_mode_t   requested_op_mode;      // Software request
   cmc_mode_t   cur_r;                  // Mode in effect
   logic [15:0] bit_timing_config_two;  // Bit time and wake filter
   logic [1:0]  rx_irq_enable;          // Per-buffer irq enable
   logic [1:0]  rx_buffer_full_flag;    // Per-buffer full flag
   logic        wake_event_flag;        // Bus activity while disabled
   logic        tx_pending_request;     // Frame queued by software
   logic        tx_aborted_flag;        // Queued frame was aborted
   logic        tx_run_r;               // Frame handed to engine
   logic [29:0] filt_r [0:5];           // Bit 29 is extended select
   cmc_id_t     mask_r [0:1];           // Acceptance masks
   logic [29:0] rxb_id_r [0:1];         // Bit 29 is frame format
   logic [63:0] rxb_dat_r [0:1];        // Stored payload
   // Bus slave state
   logic        aw_rdy_r, w_rdy_r, bv_r, ar_rdy_r, rv_r;
   logic [7:0]  aw_addr_r;
   logic [31:0] w_data_r, rdata_r;
   logic [3:0]  w_strb_r;
   logic [1:0]  bresp_r, rresp_r;
   // Line and idle detection
   logic [7:0]  bit_cnt_r;              // Cycles within one bit
   logic [3:0]  idle_cnt_r;             // Consecutive recessive bits
   logic [1:0]  lp_r;                   // Last two raw samples
   logic        lp_line_r;              // Filtered line level
   logic        rx_line_r, tx_pin_r, tx_oe_r, rx_own_r;
   logic        tx_start_r, ack_r, clr_r, frz_r, all_r, irq_r;

   // Mode decode
   wire in_init   = (cur_r == `CMC_M_INIT);
   wire in_dis    = (cur_r == `CMC_M_DISABLE);
   wire in_norm   = (cur_r == `CMC_M_NORMAL);
   wire in_loop   = (cur_r == `CMC_M_LOOP);
   wire in_all    = (cur_r == `CMC_M_ALL);
   wire in_listen = (cur_r == `CMC_M_LISTEN);
   wire rx_on     = in_norm | in_loop | in_all | in_listen;
   wire tx_mode   = in_norm | in_loop;
   // Codes 101 and 110 name no mode and are never entered
   wire req_legal = (requested_op_mode != 3'h5) &&
                    (requested_op_mode != 3'h6);

   // Receive line: loopback source, then optional low-pass filter
   wire rx_src  = in_loop ? core_tx_bit : bus_receive_pin;
   wire lp_use  = in_dis & bit_timing_config_two[`CMC_WAKE_LINE_FILTER_ENABLE_BIT];
   wire line_w  = lp_use ? lp_line_r : rx_src;

   // Bit time divider and idle detection; a shortened bit time acts at once
   wire bit_tick = (bit_cnt_r >= bit_timing_config_two[7:0]);
   wire bus_idle = (idle_cnt_r == `CMC_IDLE_BITS);

   // Mode change is accepted only on an idle bus
   wire init_hold = (requested_op_mode == `CMC_M_INIT) &
                    (tx_busy | tx_run_r);
   wire mode_go   = (requested_op_mode != cur_r) & req_legal &
                    bus_idle & ~init_hold;

   // Transmit start and abort
   wire tx_go  = tx_pending_request & ~tx_run_r & tx_mode &
                 (requested_op_mode == cur_r) & bus_idle;
   wire tx_abt = tx_pending_request & ~tx_run_r &
                 (requested_op_mode == `CMC_M_DISABLE);

   // Acceptance filtering: one comparator per filter
   wire [5:0] match;
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_filt
         // Standard frames compare only the low eleven bits
         wire cmc_id_t span = rx_msg_ide ? '1 : `CMC_STD_ID_MASK;
         wire cmc_id_t msk  = mask_r[gi < 2 ? 0 : 1] & span;
         assign match[gi] = (filt_r[gi][29] == rx_msg_ide) &&
            (((rx_msg_id ^ filt_r[gi][28:0]) & msk) == '0);
      end
   endgenerate
   wire hit0  = |match[1:0];
   wire hit1  = |match[5:2];
   // Errored frames are kept only when every message is accepted
   wire rx_ev = rx_on & (rx_msg_valid | (in_all & rx_msg_error));
   wire dst0  = rx_ev & (in_all | hit0) & ~rx_buffer_full_flag[0];
   wire dst1  = rx_ev & ~in_all & ~hit0 & hit1 &
                ~rx_buffer_full_flag[1];

   // Register write decode
   wire wr_go    = ~aw_rdy_r & ~w_rdy_r & ~bv_r;
   wire [5:0] wi = aw_addr_r[7:2];
   wire wr_ctrl  = wr_go & (aw_addr_r == `CMC_CTRL_OFS);
   wire wr_tim   = wr_go & (aw_addr_r == `CMC_TIMING_OFS) & in_init;
   wire wr_flag  = wr_go & (aw_addr_r == `CMC_FLAGS_OFS);
   wire wr_ien   = wr_go & (aw_addr_r == `CMC_IRQEN_OFS) & in_init;
   wire wr_tx    = wr_go & (aw_addr_r == `CMC_TXCTL_OFS);
   wire wr_filt  = wr_go & in_init & (wi >= 6'h08) & (wi <= 6'h0d);
   wire wr_mask  = wr_go & in_init & (wi >= 6'h0e) & (wi <= 6'h0f);
   wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                        {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   wire [31:0] wbits = w_data_r & wmask;
   // Flags clear by writing one; a store in the same cycle wins
   wire [1:0] flag_nxt = (rx_buffer_full_flag &
                          ~({2{wr_flag}} & wbits[1:0])) | {dst1, dst0};
   wire wr_map = (aw_addr_r <= `CMC_TXCTL_OFS) |
                 ((wi >= 6'h08) & (wi <= 6'h0f));

   // Read decode
   wire [5:0] ri = s_axi_araddr[7:2];
   wire [1:0] rb = ri[2] ? 2'h1 : 2'h0;
   wire       rs = (s_axi_araddr >= `CMC_RX_BUFFER_ONE_OFS);
   wire [31:0] rd_mux =
      (ri == 6'h00) ? {21'h0, requested_op_mode, cur_r, 5'h0} :
      (ri == 6'h01) ? {16'h0, bit_timing_config_two} :
      (ri == 6'h02) ? {29'h0, wake_event_flag, rx_buffer_full_flag} :
      (ri == 6'h03) ? {30'h0, rx_irq_enable} :
      (ri == 6'h04) ? {30'h0, tx_aborted_flag, tx_pending_request} :
      (ri >= 6'h08 && ri <= 6'h0d) ?
         {filt_r[3'(ri - 6'h08)][29], 2'h0, filt_r[3'(ri - 6'h08)][28:0]} :
      (ri == 6'h0e) ? {3'h0, mask_r[0]} :
      (ri == 6'h0f) ? {3'h0, mask_r[1]} :
      ((ri[5:3] == 3'h2) && (rb != 2'h3) && !(rs && ri[1:0] == 2'h3)) ?
         ((ri[1:0] == 2'h0) ? {rxb_id_r[rs][29], 2'h0, rxb_id_r[rs][28:0]} :
          (ri[1:0] == 2'h1) ? rxb_dat_r[rs][31:0] :
          (ri[1:0] == 2'h2) ? rxb_dat_r[rs][63:32] : 32'h0) : 32'h0;
   wire rd_map = (ri <= 6'h04) | ((ri >= 6'h08) & (ri <= 6'h0f)) |
                 (ri == 6'h10) | (ri == 6'h11) | (ri == 6'h12) |
                 (ri == 6'h14) | (ri == 6'h15) | (ri == 6'h16);

   // Write address and data channels, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_rdy_r <= 1'b1;
         w_rdy_r  <= 1'b1;
         bv_r     <= 1'b0;
         bresp_r  <= `CMC_AXI_OKAY;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && aw_rdy_r) begin
            aw_addr_r <= s_axi_awaddr;
            aw_rdy_r  <= 1'b0;
         end
         if (s_axi_wvalid && w_rdy_r) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            w_rdy_r  <= 1'b0;
         end
         // Response follows once both halves are held
         if (wr_go) begin
            bv_r    <= 1'b1;
            bresp_r <= wr_map ? `CMC_AXI_OKAY : `CMC_AXI_SLVERR;
         end else if (bv_r && s_axi_bready) begin
            bv_r     <= 1'b0;
            aw_rdy_r <= 1'b1;
            w_rdy_r  <= 1'b1;
         end
      end
   end

   // Read channel: data one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_rdy_r <= 1'b1;
         rv_r     <= 1'b0;
         rdata_r  <= 32'h0;
         rresp_r  <= `CMC_AXI_OKAY;
      end else if (s_axi_arvalid && ar_rdy_r) begin
         ar_rdy_r <= 1'b0;
         rv_r     <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= rd_map ? `CMC_AXI_OKAY : `CMC_AXI_SLVERR;
      end else if (rv_r && s_axi_rready) begin
         rv_r     <= 1'b0;
         ar_rdy_r <= 1'b1;
      end
   end

   // Control and configuration registers; config locked when on-line
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         requested_op_mode     <= `CMC_M_INIT;
         cur_r                 <= `CMC_M_INIT;
         bit_timing_config_two <= `CMC_TIMING_RST;
         rx_irq_enable         <= 2'h0;
      end else begin
         if (wr_ctrl && w_strb_r[1])
            requested_op_mode <= w_data_r[`CMC_REQ_HI:`CMC_REQ_LO];
         if (mode_go)
            cur_r <= requested_op_mode;
         if (wr_tim)
            bit_timing_config_two <= (bit_timing_config_two &
               ~wmask[15:0]) | wbits[15:0];
         if (wr_ien && w_strb_r[0])
            rx_irq_enable <= w_data_r[1:0];
      end
   end

   // Acceptance filters and masks, writable in init mode only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 6; i++)
            filt_r[i] <= 30'h0;
         mask_r[0] <= '0;
         mask_r[1] <= '0;
      end else if (wr_filt) begin
         filt_r[3'(wi - 6'h08)] <= {wbits[`CMC_EXT_BIT], wbits[28:0]};
      end else if (wr_mask) begin
         mask_r[wi[0]] <= wbits[28:0];
      end
   end

   // Receive buffers and flags; nothing is stored in init or disable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_buffer_full_flag <= 2'h0;
         wake_event_flag     <= 1'b0;
         irq_r               <= 1'b0;
         rxb_id_r[0]  <= 30'h0;
         rxb_id_r[1]  <= 30'h0;
         rxb_dat_r[0] <= 64'h0;
         rxb_dat_r[1] <= 64'h0;
      end else begin
         rx_buffer_full_flag <= flag_nxt;
         irq_r <= |(flag_nxt & rx_irq_enable);
         // Activity wakes software even though nothing is received
         if (in_dis && !line_w)
            wake_event_flag <= 1'b1;
         else if (wr_flag && wbits[`CMC_WAKE_BIT])
            wake_event_flag <= 1'b0;
         if (dst0 || dst1) begin
            rxb_id_r[dst1]  <= {rx_msg_ide, rx_msg_id};
            rxb_dat_r[dst1] <= rx_msg_data;
         end
      end
   end

   // Transmit request, start and abort
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_pending_request <= 1'b0;
         tx_aborted_flag    <= 1'b0;
         tx_run_r           <= 1'b0;
         tx_start_r         <= 1'b0;
      end else begin
         tx_start_r <= tx_go;
         if (tx_go)
            tx_run_r <= 1'b1;
         else if (tx_done)
            tx_run_r <= 1'b0;
         if (tx_abt) begin
            tx_pending_request <= 1'b0;
            tx_aborted_flag    <= 1'b1;
         end else if (tx_run_r && tx_done) begin
            tx_pending_request <= 1'b0;
         end else if (wr_tx && wbits[0]) begin
            // A new request clears any old abort indication
            tx_pending_request <= 1'b1;
            tx_aborted_flag    <= 1'b0;
         end else if (wr_tx && wbits[1]) begin
            tx_aborted_flag <= 1'b0;
         end
      end
   end

   // Bit time divider and consecutive recessive bit counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bit_cnt_r  <= 8'h00;
         idle_cnt_r <= 4'h0;
      end else begin
         bit_cnt_r <= bit_tick ? 8'h00 : bit_cnt_r + 8'h01;
         if (bit_tick && !line_w)
            idle_cnt_r <= 4'h0;
         else if (bit_tick && !bus_idle)
            idle_cnt_r <= idle_cnt_r + 4'h1;
      end
   end

   // Low-pass filter: the line follows only three equal samples
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lp_r      <= 2'h3;
         lp_line_r <= 1'b1;
      end else begin
         lp_r <= {lp_r[0], rx_src};
         if (lp_r == {2{rx_src}})
            lp_line_r <= rx_src;
      end
   end

   // Pin ownership and engine controls, all from flip-flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_oe_r   <= 1'b0;
         tx_pin_r  <= 1'b1;
         rx_own_r  <= 1'b0;
         rx_line_r <= 1'b1;
         ack_r     <= 1'b0;
         clr_r     <= 1'b0;
         frz_r     <= 1'b0;
         all_r     <= 1'b0;
      end else begin
         tx_oe_r   <= in_norm;
         tx_pin_r  <= in_norm ? core_tx_bit : 1'b1;
         rx_own_r  <= in_norm | in_listen | in_all;
         // Idle modes present a recessive line to the engine
         rx_line_r <= rx_on ? line_w : 1'b1;
         ack_r     <= in_norm | in_loop;
         clr_r     <= in_init;
         frz_r     <= in_dis | in_listen | in_all;
         all_r     <= in_all;
      end
   end

   assign s_axi_awready     = aw_rdy_r;
   assign s_axi_wready      = w_rdy_r;
   assign s_axi_bvalid      = bv_r;
   assign s_axi_bresp       = bresp_r;
   assign s_axi_arready     = ar_rdy_r;
   assign s_axi_rvalid      = rv_r;
   assign s_axi_rdata       = rdata_r;
   assign s_axi_rresp       = rresp_r;
   assign bus_transmit_pin  = tx_pin_r;
   assign bus_transmit_oe   = tx_oe_r;
   assign bus_receive_owned = rx_own_r;
   assign bus_receive_line  = rx_line_r;
   assign tx_start          = tx_start_r;
   assign ack_enable        = ack_r;
   assign err_cnt_clear     = clr_r;
   assign err_cnt_freeze    = frz_r;
   assign accept_all        = all_r;
   assign current_op_mode   = cur_r;
   assign rx_irq            = irq_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_tx_go;
      tx_start_r ##1 tx_run_r;
   endsequence
   mode_idle_a: assert property (
      (cur_r != $past(cur_r)) |-> $past(bus_idle))
      else $error("mode changed without idle bus");
   init_wait_a: assert property (
      (tx_busy && requested_op_mode == `CMC_M_INIT && !in_init)
      |=> !in_init) else $error("init entered during frame");
   cfg_lock_a: assert property (
      !in_init |=> $stable(bit_timing_config_two))
      else $error("timing changed while on-line");
   flag_cause_a: assert property (
      $rose(rx_buffer_full_flag[0]) |-> $past(dst0))
      else $error("flag set without store");
   store_irq_a: assert property (
      (dst1 && rx_irq_enable[1]) |=> rx_irq)
      else $error("no interrupt on store");
   tx_abort_a: assert property (
      tx_abt |=> tx_aborted_flag && !tx_pending_request)
      else $error("pending frame not aborted");
   tx_start_a: assert property (
      tx_go |=> s_tx_go) else $error("start not followed by run");
   dis_pins_a: assert property (
      in_dis |=> !bus_transmit_oe && !bus_receive_owned)
      else $error("pins held in disable");
   idle_restart_a: assert property (
      (bit_tick && !line_w) |=> idle_cnt_r == 4'h0)
      else $error("idle count not restarted");
   loop_path_a: assert property (
      (in_loop && !lp_use) |=> bus_receive_line == $past(core_tx_bit))
      else $error("loopback path broken");
endmodule
`default_nettype wire

//--- rtl/cmc_cfg.svh
// Offsets, field positions, reset values and timing for the mode/rx block
`ifndef CMC_CFG_SVH
`define CMC_CFG_SVH
// Register byte offsets
`define CMC_CTRL_OFS     8'h00
`define CMC_TIMING_OFS   8'h04
`define CMC_FLAGS_OFS    8'h08
`define CMC_IRQEN_OFS    8'h0c
`define CMC_TXCTL_OFS    8'h10
`define CMC_FILT0_OFS    8'h20
`define CMC_MASK0_OFS    8'h38
`define CMC_MASK1_OFS    8'h3c
`define CMC_RX_BUFFER_ZERO_OFS     8'h40
`define CMC_RX_BUFFER_ONE_OFS     8'h50
// Field positions
`define CMC_REQ_HI       10
`define CMC_REQ_LO       8
`define CMC_CUR_HI       7
`define CMC_CUR_LO       5
`define CMC_WAKE_LINE_FILTER_ENABLE_BIT   14
`define CMC_EXT_BIT      31
`define CMC_IDE_BIT      31
`define CMC_WAKE_BIT     2
// Mode codes
`define CMC_M_NORMAL     3'h0
`define CMC_M_DISABLE    3'h1
`define CMC_M_LOOP       3'h2
`define CMC_M_LISTEN     3'h3
`define CMC_M_INIT       3'h4
`define CMC_M_ALL        3'h7
// Reset values and timing
`define CMC_TIMING_RST   16'h0018
`define CMC_IDLE_BITS    4'hb
`define CMC_STD_ID_MASK  29'h000007ff
`define CMC_AXI_OKAY     2'h0
`define CMC_AXI_SLVERR   2'h2
`endif

//--- rtl/cmc_pkg.sv
// Types shared by the mode control and receive filter block
package cmc_pkg;
   typedef logic [2:0]  cmc_mode_t;   // Operating mode code
   typedef logic [28:0] cmc_id_t;     // Message identifier
endpackage

//--- verif/cmc_peer.sv
// Far-side model: protocol engine and the other bus nodes
`timescale 1ns/1ps
`default_nettype none
module cmc_peer (
   input  wire logic        aclk,
   input  wire logic        tx_start,
   output logic             tx_busy,
   output logic             tx_done,
   output logic             bus_receive_pin,
   output logic             rx_msg_valid,
   output logic             rx_msg_error,
   output logic             rx_msg_ide,
   output cmc_pkg::cmc_id_t rx_msg_id,
   output logic [63:0]      rx_msg_data
);
   import cmc_pkg::*;
   int busy_n = 0; // Cycles left in the frame on the wire
   initial begin
      tx_done = 1'b0;
      bus_receive_pin = 1'b1;
      rx_msg_valid = 1'b0;
      rx_msg_error = 1'b0;
      rx_msg_ide = 1'b0;
      rx_msg_id = '0;
      rx_msg_data = '0;
   end
   assign tx_busy = busy_n > 0;
   // Engine runs a 20-cycle frame per start, then pulses done
   always @(posedge aclk) begin
      tx_done <= 1'b0;
      if (tx_start) begin
         busy_n <= 20;
      end else if (busy_n > 0) begin
         busy_n <= busy_n - 1;
         tx_done <= busy_n == 1;
      end
   end
   // Another node drives the wire dominant while dom is set
   task automatic hold_bus(input logic dom);
      @(posedge aclk);
      bus_receive_pin <= !dom;
      repeat (8) @(posedge aclk); // Idle detector sees the level
   endtask
   // One finished frame, good or errored, as a one-cycle pulse
   task automatic deliver(input logic ide, input cmc_id_t id,
                          input logic [63:0] d, input logic err);
      @(posedge aclk);
      rx_msg_ide <= ide;
      rx_msg_id <= id;
      rx_msg_data <= d;
      rx_msg_valid <= !err;
      rx_msg_error <= err;
      @(posedge aclk);
      rx_msg_valid <= 1'b0;
      rx_msg_error <= 1'b0;
      // Stale fields are inverted so nothing can lean on them
      rx_msg_ide <= !ide;
      rx_msg_id <= ~id;
      rx_msg_data <= ~d;
   endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for mode control and receive filtering
`timescale 1ns/1ps
`default_nettype none
`include "cmc_cfg.svh"
module testbench;
   import cmc_pkg::*;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, core_tx_bit, s_axi_awready;
   logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        bus_receive_pin, bus_transmit_pin, bus_transmit_oe;
   logic        bus_receive_owned, bus_receive_line, tx_start, tx_busy;
   logic        tx_done, ack_enable, err_cnt_clear, err_cnt_freeze;
   logic        accept_all, rx_msg_valid, rx_msg_error, rx_msg_ide, rx_irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rq[$], mq[$];
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, eq[$], bq[$];
   logic [63:0] rx_msg_data, d;
   logic [31:0] lfsr = 32'h9a04087a; // Fixed seed
   cmc_id_t     rx_msg_id;
   cmc_mode_t   current_op_mode;
   cmc_mode_t   mt[5] = '{3'h2, 3'h3, 3'h7, 3'h0, 3'h4}; // Mode walk
   int          miscompares = 0, n_checks = 0, cyc = 0, starts = 0;
   localparam logic [1:0] ok = `CMC_AXI_OKAY;
   cmc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_receive_pin,
      .bus_transmit_pin, .bus_transmit_oe, .bus_receive_owned,
      .core_tx_bit, .bus_receive_line, .tx_start, .tx_busy, .tx_done,
      .ack_enable, .err_cnt_clear, .err_cnt_freeze, .accept_all,
      .rx_msg_valid, .rx_msg_error, .rx_msg_ide, .rx_msg_id,
      .rx_msg_data, .current_op_mode, .rx_irq);
   cmc_peer peer (.aclk, .tx_start, .tx_busy, .tx_done, .bus_receive_pin,
      .rx_msg_valid, .rx_msg_error, .rx_msg_ide, .rx_msg_id, .rx_msg_data);
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Hang guard, far above the several hundred cycles the run needs
   always @(posedge aclk) begin
      cyc++;
      if (tx_start === 1'b1)
         starts++;
      if (cyc == 6000) begin
         miscompares++;
         final_report();
      end
   end
   // Answers are matched to the oldest note as they are accepted
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         chk("rdata", rq.pop_front(), s_axi_rdata & mq.pop_front());
         chk("rresp", eq.pop_front(), s_axi_rresp);
      end
      if (s_axi_bvalid && s_axi_bready)
         chk("bresp", bq.pop_front(), s_axi_bresp);
   end
   // Address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     input logic [1:0] r);
      bit aw = 1;
      bit w = 1;
      @(posedge aclk);
      bq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         if (s_axi_awready) aw = 0;
         if (s_axi_wready) w = 0;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                     input logic [1:0] r);
      @(posedge aclk);
      rq.push_back(e & m);
      mq.push_back(m);
      eq.push_back(r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   // Bounded wait for the mode, then one edge for the mode outputs
   task automatic wait_mode(input cmc_mode_t m);
      for (int n = 0; n < 200 && current_op_mode !== m; n++)
         @(posedge aclk);
      @(posedge aclk);
      #1 chk("mode", m, current_op_mode);
   endtask
   initial begin
      aresetn = 1'b0;
      core_tx_bit = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`CMC_CTRL_OFS, 32'h0490, 32'h07e0, ok);
      rd(8'h7c, 32'h0, '1, `CMC_AXI_SLVERR);
      $display("reset test done");
      wr(`CMC_TIMING_OFS, 32'h3, ok);
      for (int n = 0; n < 6; n++)
         wr(8'(32'h20 + 4 * n), n < 2 ? 32'h123 : 32'h8abcd000, ok);
      wr(`CMC_MASK0_OFS, 32'h1fffffff, ok);
      wr(`CMC_MASK1_OFS, 32'h1ffff000, ok);
      wr(`CMC_IRQEN_OFS, 32'h1, ok);
      wr(`CMC_CTRL_OFS, 32'h0, ok);
      wait_mode(`CMC_M_NORMAL);
      chk("oe", 1, bus_transmit_oe);
      d = {rnd(), rnd()};
      peer.deliver(0, 29'h123, d, 0);
      #1 chk("irq", 1, rx_irq);
      rd(`CMC_FLAGS_OFS, 32'h1, 32'h3, ok);
      rd(`CMC_RX_BUFFER_ZERO_OFS, 32'h123, '1, ok);
      rd(8'h44, d[31:0], '1, ok);
      peer.deliver(1, 29'h0abcd000 | 29'(rnd() & 32'hfff), d, 0);
      rd(`CMC_FLAGS_OFS, 32'h3, 32'h3, ok);
      rd(`CMC_RX_BUFFER_ONE_OFS, 32'h8abcd000, 32'hfffff000, ok);
      wr(`CMC_FLAGS_OFS, 32'h1, ok);
      #1 chk("irq", 0, rx_irq);
      peer.deliver(1, 29'h123, d, 0);
      wr(`CMC_FILT0_OFS, 32'h124, ok);
      peer.deliver(0, 29'h124, d, 0);
      rd(`CMC_FLAGS_OFS, 32'h2, 32'h3, ok);
      rd(`CMC_FILT0_OFS, 32'h123, '1, ok);
      $display("filter test done");
      peer.hold_bus(1);
      wr(`CMC_TXCTL_OFS, 32'h1, ok);
      repeat (80) @(posedge aclk);
      chk("starts", 0, starts);
      peer.hold_bus(0);
      for (int n = 0; n < 300 && tx_done !== 1'b1; n++)
         @(posedge aclk);
      chk("starts", 1, starts);
      rd(`CMC_TXCTL_OFS, 32'h0, 32'h1, ok);
      peer.hold_bus(1);
      wr(`CMC_TXCTL_OFS, 32'h1, ok);
      wr(`CMC_CTRL_OFS, 32'h100, ok);
      rd(`CMC_TXCTL_OFS, 32'h2, 32'h3, ok);
      repeat (80) @(posedge aclk);
      chk("mode", `CMC_M_NORMAL, current_op_mode);
      peer.hold_bus(0);
      wait_mode(`CMC_M_DISABLE);
      chk("own", 0, bus_receive_owned);
      peer.deliver(0, 29'h123, d, 0);
      peer.hold_bus(1);
      rd(`CMC_FLAGS_OFS, 32'h6, 32'h7, ok);
      peer.hold_bus(0);
      $display("transmit test done");
      foreach (mt[i]) begin
         wr(`CMC_CTRL_OFS, {21'h0, mt[i], 8'h0}, ok);
         wait_mode(mt[i]);
         chk("oe", mt[i] == 0, bus_transmit_oe);
         chk("own", mt[i] inside {0, 3, 7}, bus_receive_owned);
         chk("ack", mt[i] inside {0, 2}, ack_enable);
         chk("frz", mt[i] inside {3, 7}, err_cnt_freeze);
         chk("all", mt[i] == 7, accept_all);
         chk("clr", mt[i] == 4, err_cnt_clear);
         if (mt[i] == 7) begin
            peer.deliver(0, 29'h555, d, 1);
            rd(`CMC_FLAGS_OFS, 32'h3, 32'h3, ok);
         end
         if (mt[i] == 2) begin
            core_tx_bit <= 1'b0;
            @(posedge aclk);
            #1 chk("loop", 0, bus_receive_line);
            @(posedge aclk);
            core_tx_bit <= 1'b1;
         end
      end
      rd(`CMC_FLAGS_OFS, 32'h3, 32'h3, ok);
      $display("mode test done");
      final_report();
   end
endmodule
`default_nettype wire
